// *** include/sbr_consts.vh ***
// Register offsets, field positions and reset values of the sense and brownout slice
`ifndef SBR_CONSTS_VH
`define SBR_CONSTS_VH
// Register addresses on the control port
`define SBR_ADDR_SENSE_PATH_CONFIG 16'h20E0
`define SBR_ADDR_SENSE_PATH_ENABLES 16'h20E4
`define SBR_ADDR_BROWNOUT_LEVEL_STATUS 16'h20E5
`define SBR_ADDR_LEVEL3_TRIP_HIGH 16'h20E6
`define SBR_ADDR_LEVEL3_TRIP_LOW 16'h20E7
`define SBR_ADDR_LEVEL2_TRIP_HIGH 16'h20E8
`define SBR_ADDR_LEVEL2_TRIP_LOW 16'h20E9
// Sense path configuration fields
`define SBR_BIT_WIDEBAND_FILTER 3
`define SBR_BIT_SENSE_DITHER 2
`define SBR_BIT_CURRENT_DC_BLOCK 1
`define SBR_BIT_VOLTAGE_DC_BLOCK 0
// Path enable fields
`define SBR_BIT_CURRENT_PATH 1
`define SBR_BIT_VOLTAGE_PATH 0
// Reset values
`define SBR_RST_SENSE_PATH_CONFIG 4'h4
`define SBR_RST_SENSE_PATH_ENABLES 2'h0
`define SBR_RST_TRIP 9'h000
// Brownout level status codes
`define SBR_LEVEL_NONE 3'h0
`define SBR_LEVEL_3 3'h1
`define SBR_LEVEL_2 3'h2
`define SBR_LEVEL_1 3'h3
`define SBR_LEVEL_0 3'h4
`endif

// *** hw/sbr_level_detect.v ***
// One brownout level trip comparator with bypass on zero threshold
`timescale 1ns/1ps
module sbr_level_detect (
  input wire clk,
  input wire srst,
  input wire [8:0] trip_threshold,
  input wire [8:0] supply_code,
  output reg tripped_reg
);
  // Zero threshold marks the level unused
  wire level_used;
  assign level_used = (trip_threshold != 9'h000);

  // Registered compare keeps supply glitches off the level path
  always @(posedge clk) begin
    if (srst) begin
      tripped_reg <= 1'b0;
    end else begin
      tripped_reg <= level_used && (supply_code < trip_threshold);
    end
  end
endmodule

// *** hw/sbr_regs.v ***
// Sense path and brownout threshold register slice
// Notes on behaviour
// - Bit 3 enables wideband sense filters
// - Bit 2 enables sense path dither
// - Bit 1 enables current DC blocker
// - Bit 0 enables voltage DC blocker
// - Current path powered when enabled and active
// - Voltage path powered when enabled and active
// - Status codes 000 to 010 only
// - Status reads 000 while globally disabled
// - Nine-bit thresholds split high and low
// - Zero threshold level is skipped
//
// Register map, all byte wide on the control port:
//   0x20E0 sense_path_config, bits 3:0 read and write
//   0x20E4 sense_path_enables, bits 1:0 read and write
//   0x20E5 brownout_level_status, bits 2:0 read only
//   0x20E6 level3_trip_high, threshold bits 8:1
//   0x20E7 level3_trip_low, threshold bit 0
//   0x20E8 level2_trip_high, threshold bits 8:1
//   0x20E9 level2_trip_low, threshold bit 0
// Only levels 3 and 2 are built here; level 1 and 0 codes never appear.
// Threshold halves are written one at a time, so the comparator sees a
// mixed value between the two writes; writing the high byte first keeps
// that transient within one code of the final threshold.
// Status latency is two clocks from a supply or threshold change: one in
// the comparator flop and one in the status register.
// Power gating is combinational, so the sense paths drop with the enable.
// Low-byte writes keep only bit 0; the other seven bits read back zero.
// Reads and writes may share a cycle; the read returns the old value.
`timescale 1ns/1ps
`include "sbr_consts.vh"
module sbr_regs (
  input wire clk,
  input wire srst,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wr_data,
  output reg [7:0] reg_rd_data_reg,
  input wire global_enable,
  input wire [8:0] supply_code,
  output reg wideband_filter_enable_reg,
  output reg sense_dither_enable_reg,
  output reg current_dc_block_enable_reg,
  output reg voltage_dc_block_enable_reg,
  output wire current_path_power,
  output wire voltage_path_power,
  output reg [2:0] brownout_level_status_reg
);
  // Path enable bits as software left them
  reg current_path_enable_reg;
  reg voltage_path_enable_reg;
  // Nine-bit trip thresholds
  reg [8:0] level3_trip_threshold_reg;
  reg [8:0] level2_trip_threshold_reg;
  // Comparator outcomes
  wire level3_tripped;
  wire level2_tripped;
  // Read data next value
  reg [7:0] reg_rd_data_next;
  // Status next value
  reg [2:0] brownout_level_status_next;

  // Address hits, one per mapped register
  wire hit_sense_path_config;
  wire hit_sense_path_enables;
  wire hit_brownout_level_status;
  wire hit_level3_trip_high;
  wire hit_level3_trip_low;
  wire hit_level2_trip_high;
  wire hit_level2_trip_low;

  // Full sixteen-bit compare, so aliases near the map never hit
  assign hit_sense_path_config = (reg_addr == `SBR_ADDR_SENSE_PATH_CONFIG);
  assign hit_sense_path_enables = (reg_addr == `SBR_ADDR_SENSE_PATH_ENABLES);
  assign hit_brownout_level_status = (reg_addr == `SBR_ADDR_BROWNOUT_LEVEL_STATUS);
  assign hit_level3_trip_high = (reg_addr == `SBR_ADDR_LEVEL3_TRIP_HIGH);
  assign hit_level3_trip_low = (reg_addr == `SBR_ADDR_LEVEL3_TRIP_LOW);
  assign hit_level2_trip_high = (reg_addr == `SBR_ADDR_LEVEL2_TRIP_HIGH);
  assign hit_level2_trip_low = (reg_addr == `SBR_ADDR_LEVEL2_TRIP_LOW);

  // Level 3 trip detector
  // Each detector adds one clock of status latency
  sbr_level_detect u_level3 (
    .clk(clk),
    .srst(srst),
    .trip_threshold(level3_trip_threshold_reg),
    .supply_code(supply_code),
    .tripped_reg(level3_tripped)
  );

  // Level 2 trip detector
  // Same detector, its own threshold
  sbr_level_detect u_level2 (
    .clk(clk),
    .srst(srst),
    .trip_threshold(level2_trip_threshold_reg),
    .supply_code(supply_code),
    .tripped_reg(level2_tripped)
  );

  // Power gating follows the global enable directly, so disable is immediate
  // No settling delay is modelled for the analog paths behind these pins
  // Requests written while inactive take effect once the device is active
  // current and voltage path gating
  assign current_path_power = current_path_enable_reg & global_enable;
  assign voltage_path_power = voltage_path_enable_reg & global_enable;

  // Register writes; unmapped and read-only addresses ignore writes
  // The status code has no write path, so a stray write cannot fake a level
  always @(posedge clk) begin
    if (srst) begin
      // Reset values; dither is on out of reset
      {wideband_filter_enable_reg, sense_dither_enable_reg,
        current_dc_block_enable_reg, voltage_dc_block_enable_reg} <=
        `SBR_RST_SENSE_PATH_CONFIG;
      {current_path_enable_reg, voltage_path_enable_reg} <= `SBR_RST_SENSE_PATH_ENABLES;
      // Zero thresholds leave both levels unused until programmed
      level3_trip_threshold_reg <= `SBR_RST_TRIP;
      level2_trip_threshold_reg <= `SBR_RST_TRIP;
    end else if (reg_wr_en) begin
      if (hit_sense_path_config) begin
        wideband_filter_enable_reg <= reg_wr_data[`SBR_BIT_WIDEBAND_FILTER];
        sense_dither_enable_reg <= reg_wr_data[`SBR_BIT_SENSE_DITHER];
        current_dc_block_enable_reg <= reg_wr_data[`SBR_BIT_CURRENT_DC_BLOCK];
        voltage_dc_block_enable_reg <= reg_wr_data[`SBR_BIT_VOLTAGE_DC_BLOCK];
      end else if (hit_sense_path_enables) begin
        current_path_enable_reg <= reg_wr_data[`SBR_BIT_CURRENT_PATH];
        voltage_path_enable_reg <= reg_wr_data[`SBR_BIT_VOLTAGE_PATH];
      end else if (hit_level3_trip_high) begin
        level3_trip_threshold_reg[8:1] <= reg_wr_data;
      end else if (hit_level3_trip_low) begin
        // least significant bit, bits 7:1 dropped
        level3_trip_threshold_reg[0] <= reg_wr_data[0];
      end else if (hit_level2_trip_high) begin
        level2_trip_threshold_reg[8:1] <= reg_wr_data;
      end else if (hit_level2_trip_low) begin
        level2_trip_threshold_reg[0] <= reg_wr_data[0];
      end
    end
  end

  // Level selection; only levels 3 and 2 live in this slice
  // Priority chain, so a deeper level masks a shallower one
  // Disabled device reports inactive whatever the comparators say
  always @* begin
    // Default: no brownout
    brownout_level_status_next = `SBR_LEVEL_NONE;
    if (!global_enable) begin
      brownout_level_status_next = `SBR_LEVEL_NONE;
    end else if (level2_tripped) begin
      brownout_level_status_next = `SBR_LEVEL_2;
    end else if (level3_tripped) begin
      brownout_level_status_next = `SBR_LEVEL_3;
    end
  end

  // Status register; reserved codes never produced
  // Registered; a read matches the port except in the first clock after disable, when it returns 000 and the port keeps the old code
  always @(posedge clk) begin
    if (srst) begin
      // Inactive code out of reset
      brownout_level_status_reg <= `SBR_LEVEL_NONE;
    end else begin
      brownout_level_status_reg <= brownout_level_status_next;
    end
  end

  // Read mux; reserved bits and unmapped addresses read zero
  // Sampled into the read register only on a read strobe
  always @* begin
    // Default covers reserved bits and unmapped addresses
    reg_rd_data_next = 8'h00;
    if (hit_sense_path_config) begin
      // Configuration bits in field order
      reg_rd_data_next[3:0] = {wideband_filter_enable_reg, sense_dither_enable_reg,
        current_dc_block_enable_reg, voltage_dc_block_enable_reg};
    end else if (hit_sense_path_enables) begin
      // Path requests, not the gated power state
      reg_rd_data_next[1:0] = {current_path_enable_reg, voltage_path_enable_reg};
    end else if (hit_brownout_level_status) begin
      reg_rd_data_next[2:0] = global_enable ? brownout_level_status_reg : `SBR_LEVEL_NONE;
    end else if (hit_level3_trip_high) begin
      // Level 3 threshold bits 8:1
      reg_rd_data_next = level3_trip_threshold_reg[8:1];
    end else if (hit_level3_trip_low) begin
      // Level 3 threshold bit 0 alone
      reg_rd_data_next[0] = level3_trip_threshold_reg[0];
    end else if (hit_level2_trip_high) begin
      // Level 2 threshold bits 8:1
      reg_rd_data_next = level2_trip_threshold_reg[8:1];
    end else if (hit_level2_trip_low) begin
      // Level 2 threshold bit 0 alone
      reg_rd_data_next[0] = level2_trip_threshold_reg[0];
    end
  end

  // Read data held until the next read
  // Holding the value lets a slow host fetch it well after the strobe
  // A write in the same cycle is not seen; the mux still shows the old value
  always @(posedge clk) begin
    if (srst) begin
      // Cleared by reset
      reg_rd_data_reg <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rd_data_reg <= reg_rd_data_next;
    end
  end
endmodule

// *** verification/sbr_regs_asserts.sv ***
// Port-level checks for the sense and brownout register slice
`timescale 1ns/1ps
module sbr_asserts (
  input wire clk,
  input wire srst,
  input wire reg_wr_en,
  input wire reg_rd_en,
  input wire [15:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire [7:0] reg_rd_data_reg,
  input wire global_enable,
  input wire [8:0] supply_code,
  input wire wideband_filter_enable_reg,
  input wire sense_dither_enable_reg,
  input wire current_dc_block_enable_reg,
  input wire voltage_dc_block_enable_reg,
  input wire current_path_power,
  input wire voltage_path_power,
  input wire [2:0] brownout_level_status_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Config outputs gathered in bit order
  wire [3:0] cfg = {wideband_filter_enable_reg, sense_dither_enable_reg,
    current_dc_block_enable_reg, voltage_dc_block_enable_reg};
  wire cfg_wr = reg_wr_en && reg_addr == 16'h20E0;
  wire st_rd = reg_rd_en && reg_addr == 16'h20E5;
  a_wide_filter_wr: assert property (cfg_wr |=> cfg[3] == $past(reg_wr_data[3]))
    else $error("wideband bit not taken");
  a_dither_wr: assert property (cfg_wr |=> cfg[2] == $past(reg_wr_data[2]))
    else $error("dither bit not taken");
  a_cur_block_wr: assert property (cfg_wr |=> cfg[1] == $past(reg_wr_data[1]))
    else $error("current blocker bit not taken");
  a_volt_block_wr: assert property (cfg_wr |=> cfg[0] == $past(reg_wr_data[0]))
    else $error("voltage blocker bit not taken");
  a_cur_power_gate: assert property (current_path_power |-> global_enable)
    else $error("current path powered while inactive");
  a_volt_power_gate: assert property (voltage_path_power |-> global_enable)
    else $error("voltage path powered while inactive");
  a_status_code_range: assert property (brownout_level_status_reg <= 3'h2)
    else $error("status code out of range");
  a_status_idle_off: assert property (!global_enable |=> brownout_level_status_reg == 3'h0)
    else $error("status not cleared while inactive");
  a_status_read_off: assert property (st_rd && !global_enable |=> reg_rd_data_reg == 8'h00)
    else $error("status read not zero while inactive");
  // Main scenarios reached
  cover property (cfg_wr);
  cover property (brownout_level_status_reg == 3'h2);
  cover property (current_path_power && !voltage_path_power);
  cover property (brownout_level_status_reg == 3'h1);
endmodule
bind sbr_regs sbr_asserts sbr_asserts_inst (
  .clk(clk),
  .srst(srst),
  .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data),
  .reg_rd_data_reg(reg_rd_data_reg),
  .global_enable(global_enable),
  .supply_code(supply_code),
  .wideband_filter_enable_reg(wideband_filter_enable_reg),
  .sense_dither_enable_reg(sense_dither_enable_reg),
  .current_dc_block_enable_reg(current_dc_block_enable_reg),
  .voltage_dc_block_enable_reg(voltage_dc_block_enable_reg),
  .current_path_power(current_path_power),
  .voltage_path_power(voltage_path_power),
  .brownout_level_status_reg(brownout_level_status_reg)
);

// *** verification/testbench.sv ***
// Self-checking bench for the sense and brownout register slice
`timescale 1ns/1ps
module testbench;
  logic clk = 0, srst = 1, reg_wr_en = 0, reg_rd_en = 0, global_enable = 1;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wr_data = 8'h00;
  logic [8:0] supply_code = 9'h1FF; // High supply, no trip
  wire [7:0] reg_rd_data_reg;
  wire wideband_filter_enable_reg, sense_dither_enable_reg, current_dc_block_enable_reg;
  wire voltage_dc_block_enable_reg, current_path_power, voltage_path_power;
  wire [2:0] brownout_level_status_reg;
  int failures = 0, samples_checked = 0;
  // Rows: address, write data, expected read back
  logic [31:0] rows [9] = '{32'h20E00F0F, 32'h20E0F000, 32'h20E4FF03, 32'h20E6A5A5,
    32'h20E7FF01, 32'h20E85A5A, 32'h20E9FE00, 32'h20E5FF00, 32'h20EAFF00};
  sbr_regs sbr_regs_inst (
    .clk(clk),
    .srst(srst),
    .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data),
    .reg_rd_data_reg(reg_rd_data_reg),
    .global_enable(global_enable),
    .supply_code(supply_code),
    .wideband_filter_enable_reg(wideband_filter_enable_reg),
    .sense_dither_enable_reg(sense_dither_enable_reg),
    .current_dc_block_enable_reg(current_dc_block_enable_reg),
    .voltage_dc_block_enable_reg(voltage_dc_block_enable_reg),
    .current_path_power(current_path_power),
    .voltage_path_power(voltage_path_power),
    .brownout_level_status_reg(brownout_level_status_reg)
  );
  always #50 clk = ~clk;
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk) {reg_wr_en, reg_addr, reg_wr_data} = {1'b1, a, d};
    @(negedge clk) reg_wr_en = 0;
  endtask
  // Read data settles one edge after the strobe is taken
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk) {reg_rd_en, reg_addr} = {1'b1, a};
    @(negedge clk) reg_rd_en = 0;
    chk(reg_rd_data_reg, e);
  endtask
  // Status lags the supply code by two edges
  task lvl(input logic [8:0] s, input logic [2:0] e);
    @(negedge clk) supply_code = s;
    repeat (3) @(negedge clk);
    chk({5'h00, brownout_level_status_reg}, {5'h00, e});
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Guard against a stuck run
  initial begin
    #2000000;
    failures++;
    stop_test;
  end
  initial begin
    repeat (16) @(negedge clk);
    srst = 0;
    rd(16'h20E0, 8'h04);
    for (int i = 4; i < 10; i++) rd(16'h20E0 + i[15:0], 8'h00);
    chk({4'h0, wideband_filter_enable_reg, sense_dither_enable_reg,
      current_dc_block_enable_reg, voltage_dc_block_enable_reg}, 8'h04);
    $display("reset test done");
    foreach (rows[i]) begin
      // Threshold rows are picked in the supply code scale
      wr(rows[i][31:16], rows[i][15:8]);
      rd(rows[i][31:16], rows[i][7:0]);
    end
    $display("register table test done");
    wr(16'h20E0, 8'h0A);
    chk({4'h0, wideband_filter_enable_reg, sense_dither_enable_reg,
      current_dc_block_enable_reg, voltage_dc_block_enable_reg}, 8'h0A);
    chk({6'h00, current_path_power, voltage_path_power}, 8'h03);
    @(negedge clk) global_enable = 0;
    #1 chk({6'h00, current_path_power, voltage_path_power}, 8'h00);
    @(negedge clk) global_enable = 1;
    wr(16'h20E4, 8'h02);
    chk({6'h00, current_path_power, voltage_path_power}, 8'h02);
    $display("power gating test done");
    // Level 3 trips below 0x14B, level 2 below 0x0B4
    lvl(9'h14B, 3'h0);
    lvl(9'h14A, 3'h1);
    lvl(9'h0B3, 3'h2);
    rd(16'h20E5, 8'h02);
    wr(16'h20E8, 8'h00);
    lvl(9'h010, 3'h1);
    @(negedge clk) global_enable = 0;
    rd(16'h20E5, 8'h00);
    lvl(9'h010, 3'h0);
    $display("brownout test done");
    // Mid-run reset must restore every written register
    @(negedge clk) global_enable = 1;
    @(negedge clk) srst = 1;
    @(negedge clk) srst = 0;
    chk({4'h0, wideband_filter_enable_reg, sense_dither_enable_reg,
      current_dc_block_enable_reg, voltage_dc_block_enable_reg}, 8'h04);
    chk({6'h00, current_path_power, voltage_path_power}, 8'h00);
    for (int i = 6; i < 10; i++) rd(16'h20E0 + i[15:0], 8'h00);
    lvl(9'h010, 3'h0);
    $display("mid-run reset test done");
    stop_test;
  end
endmodule
